// file: core/ang_params.svh
// Offsets, field positions, reset values and widths of the negotiation register bank
`ifndef ANG_PARAMS_SVH
`define ANG_PARAMS_SVH

`define ANG_ADDR_W 5
`define ANG_DATA_W 16
`define ANG_EV_W 3

`define ANG_OFS_CTRL 5'h00
`define ANG_OFS_STAT 5'h01
`define ANG_OFS_ADV 5'h04
`define ANG_OFS_LPA 5'h05
`define ANG_OFS_EXP 5'h06
`define ANG_OFS_IST 5'h18
`define ANG_OFS_IMSK 5'h19

`define ANG_CTRL_SWRST 15
`define ANG_CTRL_RESTART 9
`define ANG_CTRL_RD_VAL 16'h0140
`define ANG_STAT_FIXED 16'h0149
`define ANG_STAT_DONE 5

`define ANG_ADV_HW_RST 16'h0C01
`define ANG_SEL_IEEE 5'h01

`define ANG_EXP_PDF 4
`define ANG_EXP_LPNP 3
`define ANG_EXP_NPA 2
`define ANG_EXP_PGR 1
`define ANG_EXP_LPAN 0
`define ANG_EXP_NPA_RST 1'b1

`define ANG_EV_PAGE 0
`define ANG_EV_PDF 1
`define ANG_EV_DONE 2

`endif

// file: core/ang_pkg.sv
// Types shared by the negotiation register bank
package ang_pkg;

  // Pause capability encoding, local and partner alike
  typedef enum logic [1:0] {
    ANG_PAUSE_NONE = 2'h0,
    ANG_PAUSE_SYM = 2'h1,
    ANG_PAUSE_ASYM = 2'h2,
    ANG_PAUSE_BOTH = 2'h3
  } ang_pause_t;

  // Local advertisement word layout
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic rf;
    logic rsv12;
    ang_pause_t pause;
    logic [4:0] rsv_mid;
    logic [4:0] sel;
  } ang_adv_t;

  // Base page as received from the link partner
  typedef struct packed {
    logic np;
    logic ack;
    logic rf;
    logic rsv12;
    ang_pause_t pause;
    logic [4:0] rsv_mid;
    logic [4:0] sel;
  } ang_page_t;

endpackage

// file: core/ang_sticky.sv
// Sticky flag bank: set wins over clear, frozen while the clock enable is low
`timescale 1ns/10ps
`default_nettype none

module ang_sticky #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_bad_width
    $error("ang_sticky needs at least one flag");
  end

  // One flop per flag; an event in the clearing cycle is kept
  for (genvar g = 0; g < WIDTH; g++) begin : g_flag
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        q[g] <= 1'b0;
      end else if (ce) begin
        if (set[g]) begin
          q[g] <= 1'b1;
        end else if (clr[g]) begin
          q[g] <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: core/ang_regs.sv
// Auto-negotiation advertisement, partner ability and expansion registers
`timescale 1ns/10ps
`default_nettype none
`include "ang_params.svh"

// What this block does
// R1: Software preserves the two top reserved advertisement bits when writing.
// R2: Local remote-fault bit 13 is writable, cleared by hard reset, kept by soft reset.
// R3: New remote-fault and pause values apply only at the next negotiation restart or link loss.
// R4: Local pause field encodes both, asymmetric, symmetric, none; resets to 11.
// R5: Advertisement selector bits 4:0 are read-only, fixed at 00001.
// R6: Partner bit 15 reports partner next page ability, resets to zero.
// R7: Partner bit 14 reports partner acknowledge of our code word.
// R8: Partner bit 13 reports partner remote fault.
// R9: Partner pause field read-only, same encoding, resets to 00 on both resets.
// R10: Expansion bit 4 reports a parallel detection fault.
// R11: Software ignores expansion contents until negotiation complete reads one.
// R12: Expansion bit 3 reports partner next page ability.
// R13: Expansion bit 2 reports local next page ability, resets to one.
// R14: Expansion bit 1 latches high when a new page arrives, resets zero.
// R15: Expansion bit 0 reports partner negotiation ability.
// R16: Page received flag clears on expansion read unless a new page arrives.
// R17: Writing control bit 9 restarts negotiation; the bit clears itself.
// R18: Status bit 5 reads one once negotiation has completed.
module ang_regs
  import ang_pkg::*;
#(
  parameter int ADDR_W = `ANG_ADDR_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic PAGE_RX,
  input wire ang_page_t PAGE_WORD,
  input wire logic PD_FAULT,
  input wire logic PARTNER_NP_ABLE,
  input wire logic PARTNER_AN_ABLE,
  input wire logic AN_COMPLETE,
  input wire logic LINK_DOWN,
  output logic AN_RESTART,
  output ang_adv_t ADV_WORD,
  output logic IRQ
);

  if (ADDR_W < 5) begin : g_bad_addr
    $error("ang_regs needs at least five address bits");
  end

  // Address decode, qualified by the clock enable
  logic sel_ctrl, sel_adv, sel_exp, sel_ist, sel_imsk;
  logic wr_ctrl, wr_adv, wr_ist, wr_imsk, rd_exp, sw_rst;
  assign sel_ctrl = (ADDR == ADDR_W'(`ANG_OFS_CTRL));
  assign sel_adv = (ADDR == ADDR_W'(`ANG_OFS_ADV));
  assign sel_exp = (ADDR == ADDR_W'(`ANG_OFS_EXP));
  assign sel_ist = (ADDR == ADDR_W'(`ANG_OFS_IST));
  assign sel_imsk = (ADDR == ADDR_W'(`ANG_OFS_IMSK));
  assign wr_ctrl = CE && WR && sel_ctrl;
  assign wr_adv = CE && WR && sel_adv;
  assign wr_ist = CE && WR && sel_ist;
  assign wr_imsk = CE && WR && sel_imsk;
  assign rd_exp = CE && RD && sel_exp;
  // Soft reset is a one-cycle pulse; the bit reads back as zero
  assign sw_rst = wr_ctrl && WDATA[`ANG_CTRL_SWRST];

  // Local advertisement; reserved bits stored as written, software keeps them
  ang_adv_t adv_r;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      adv_r <= ang_adv_t'(`ANG_ADV_HW_RST); // [R2] [R4]
    end else if (CE) begin
      if (wr_adv) begin
        adv_r.rsv_hi <= WDATA[15:14]; // [R1]
        adv_r.rf <= WDATA[13]; // [R2]
        adv_r.rsv12 <= WDATA[12];
        adv_r.pause <= ang_pause_t'(WDATA[11:10]); // [R4]
        adv_r.rsv_mid <= WDATA[9:5];
      end else if (sw_rst) begin
        // Soft reset clears only the fields that do not retain
        adv_r.rsv_hi <= 2'h0;
        adv_r.rsv_mid <= 5'h00;
      end
      adv_r.sel <= `ANG_SEL_IEEE; // [R5]
    end
  end

  // Restart pulse; the control bit never reads back as one
  logic restart_r;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      restart_r <= 1'b0;
    end else if (CE) begin
      restart_r <= wr_ctrl && WDATA[`ANG_CTRL_RESTART]; // [R17]
    end
  end
  assign AN_RESTART = restart_r;

  // Applied word changes only at a restart or on link loss, so a half-written
  // advertisement never reaches the link mid-negotiation
  logic apply;
  assign apply = restart_r || LINK_DOWN;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ADV_WORD <= ang_adv_t'(`ANG_ADV_HW_RST);
    end else if (CE && apply) begin
      ADV_WORD <= adv_r; // [R3]
    end
  end

  // Partner base page, reserved fields forced to zero
  ang_page_t lpa_r;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lpa_r <= '0; // [R9]
    end else if (CE) begin
      if (PAGE_RX) begin
        lpa_r.np <= PAGE_WORD.np; // [R6]
        lpa_r.ack <= PAGE_WORD.ack; // [R7]
        lpa_r.rf <= PAGE_WORD.rf; // [R8]
        lpa_r.rsv12 <= 1'b0;
        lpa_r.pause <= PAGE_WORD.pause; // [R9]
        lpa_r.rsv_mid <= 5'h00;
        lpa_r.sel <= PAGE_WORD.sel;
      end else if (sw_rst) begin
        lpa_r <= '0; // [R9]
      end
    end
  end

  // Live expansion and status flags, sampled once per enabled cycle
  logic pdf_r, lpnp_r, lpan_r, done_r, npa_r;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pdf_r <= 1'b0;
      lpnp_r <= 1'b0;
      lpan_r <= 1'b0;
      done_r <= 1'b0;
      npa_r <= `ANG_EXP_NPA_RST; // [R13]
    end else if (CE) begin
      if (sw_rst) begin
        pdf_r <= 1'b0;
        lpnp_r <= 1'b0;
        lpan_r <= 1'b0;
        done_r <= 1'b0;
      end else begin
        pdf_r <= PD_FAULT; // [R10]
        lpnp_r <= PARTNER_NP_ABLE; // [R12]
        lpan_r <= PARTNER_AN_ABLE; // [R15]
        done_r <= AN_COMPLETE; // [R18]
      end
      npa_r <= `ANG_EXP_NPA_RST; // [R13]
    end
  end

  // Page received latch; a read returns the old value then clears it, unless a new page arrives in that cycle
  logic pgr;
  ang_sticky #(
    .WIDTH(1)
  ) u_pgr (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .set(PAGE_RX), // [R14]
    .clr(rd_exp || sw_rst), // [R16]
    .q(pgr)
  );

  // Interrupt events: new page, fault onset, negotiation done onset
  logic [`ANG_EV_W-1:0] ev, ist, imsk_r, ist_clr;
  assign ev[`ANG_EV_PAGE] = PAGE_RX;
  assign ev[`ANG_EV_PDF] = PD_FAULT && !pdf_r;
  assign ev[`ANG_EV_DONE] = AN_COMPLETE && !done_r;
  assign ist_clr = wr_ist ? WDATA[`ANG_EV_W-1:0] : '0;

  ang_sticky #(
    .WIDTH(`ANG_EV_W)
  ) u_ist (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .set(ev),
    .clr(ist_clr),
    .q(ist)
  );

  // Mask register, same layout as the status bits
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      imsk_r <= '0;
    end else if (wr_imsk) begin
      imsk_r <= WDATA[`ANG_EV_W-1:0];
    end
  end
  assign IRQ = |(ist & imsk_r);

  // Read mux; unmapped addresses answer zero
  logic [15:0] rd_nxt;
  always_comb begin
    rd_nxt = 16'h0000;
    case (ADDR)
      ADDR_W'(`ANG_OFS_CTRL): rd_nxt = `ANG_CTRL_RD_VAL;
      ADDR_W'(`ANG_OFS_STAT): begin
        rd_nxt = `ANG_STAT_FIXED;
        rd_nxt[`ANG_STAT_DONE] = done_r; // [R18]
      end
      ADDR_W'(`ANG_OFS_ADV): rd_nxt = adv_r; // [R5]
      ADDR_W'(`ANG_OFS_LPA): rd_nxt = lpa_r;
      ADDR_W'(`ANG_OFS_EXP): begin
        // Only meaningful once negotiation is done; software checks first
        rd_nxt[`ANG_EXP_PDF] = pdf_r; // [R10]
        rd_nxt[`ANG_EXP_LPNP] = lpnp_r; // [R12]
        rd_nxt[`ANG_EXP_NPA] = npa_r; // [R13]
        rd_nxt[`ANG_EXP_PGR] = pgr; // [R14]
        rd_nxt[`ANG_EXP_LPAN] = lpan_r; // [R15]
      end
      ADDR_W'(`ANG_OFS_IST): rd_nxt[`ANG_EV_W-1:0] = ist;
      ADDR_W'(`ANG_OFS_IMSK): rd_nxt[`ANG_EV_W-1:0] = imsk_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      RDATA <= RD ? rd_nxt : 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_rf_write: assert property (wr_adv |=> adv_r.rf == $past(WDATA[13])) // [R2]
    else $error("remote fault bit not stored");
  a_rf_keep: assert property (sw_rst && !wr_adv |=> $stable(adv_r.rf)) // [R2]
    else $error("soft reset changed remote fault");
  a_adv_hold: assert property (!apply |=> $stable(ADV_WORD)) // [R3]
    else $error("applied word changed without restart");
  a_adv_apply: assert property (CE && apply |=> ADV_WORD == $past(adv_r)) // [R3]
    else $error("applied word not taken at restart");
  a_pause_read: assert property (CE && RD && sel_adv |=>
    RDATA[11:10] == $past(adv_r.pause)) // [R4]
    else $error("pause read wrong");
  a_sel_fixed: assert property (CE && RD && sel_adv |=> RDATA[4:0] == 5'h01) // [R5]
    else $error("selector not fixed");
  a_page_fields: assert property (CE && PAGE_RX |=>
    lpa_r[15:13] == $past(PAGE_WORD[15:13])) // [R6]
    else $error("partner bits not latched");
  a_lpa_swrst: assert property (sw_rst && !PAGE_RX |=> lpa_r.pause == 2'h0) // [R9]
    else $error("partner pause not cleared");
  a_pdf_follow: assert property (CE && !sw_rst |=> pdf_r == $past(PD_FAULT)) // [R10]
    else $error("fault flag lags");
  a_npa_one: assert property (CE && RD && sel_exp |=> RDATA[2]) // [R13]
    else $error("local next page able low");
  a_page_latch: assert property (CE && PAGE_RX |=> pgr [*1] ##1 1) // [R14]
    else $error("page flag not set");
  a_page_clear: assert property (rd_exp && !PAGE_RX |=> !pgr) // [R16]
    else $error("page flag not cleared by read");
  a_restart: assert property (wr_ctrl && WDATA[9] |=> AN_RESTART) // [R17]
    else $error("restart pulse missing");
  a_restart_sc: assert property (CE && !(wr_ctrl && WDATA[9]) |=> !AN_RESTART) // [R17]
    else $error("restart did not self clear");
  a_done_read: assert property (CE && RD && sel_ctrl == 1'b0 &&
    ADDR == ADDR_W'(`ANG_OFS_STAT) |=> RDATA[5] == $past(done_r)) // [R18]
    else $error("completion bit wrong");

  // Read-back and flag tracking; these catch a broken mux or a lost latch
  a_page_wins: assert property (rd_exp && PAGE_RX |=> pgr) // [R16]
    else $error("page flag lost to read clear");

  a_lpa_pause: assert property (CE && PAGE_RX |=> lpa_r.pause == $past(PAGE_WORD.pause)) // [R9]
    else $error("partner pause not latched");

  a_lpa_rsv: assert property (lpa_r.rsv12 == 1'b0 && lpa_r.rsv_mid == 5'h00) // [R9]
    else $error("partner reserved bits set");

  a_lpnp_follow: assert property (CE && !sw_rst |=> lpnp_r == $past(PARTNER_NP_ABLE)) // [R12]
    else $error("partner next page flag lags");

  a_lpan_follow: assert property (CE && !sw_rst |=> lpan_r == $past(PARTNER_AN_ABLE)) // [R15]
    else $error("partner negotiation flag lags");

  a_done_follow: assert property (CE && !sw_rst |=> done_r == $past(AN_COMPLETE)) // [R18]
    else $error("completion flag lags");

  a_exp_read: assert property (CE && RD && sel_exp |=> // [R10]
    RDATA == {11'h000, $past(pdf_r), $past(lpnp_r), 1'b1, $past(pgr), $past(lpan_r)})
    else $error("expansion read wrong");

  a_lpa_read: assert property (CE && RD && ADDR == ADDR_W'(`ANG_OFS_LPA) |=> // [R6]
    RDATA == $past(lpa_r))
    else $error("partner read wrong");

  a_swrst_page: assert property (sw_rst && !PAGE_RX |=> !pgr && !lpa_r.np) // [R14]
    else $error("soft reset kept page state");

  a_rf_hold: assert property (!wr_adv |=> $stable(adv_r.rf)) // [R2]
    else $error("remote fault changed without write");

  a_pause_hold: assert property (!wr_adv |=> $stable(adv_r.pause)) // [R4]
    else $error("pause changed without write");

  a_sel_const: assert property (adv_r.sel == `ANG_SEL_IEEE) // [R5]
    else $error("selector field moved");

  a_npa_const: assert property (npa_r) // [R13]
    else $error("local next page able dropped");

  a_ist_page: assert property (CE && ev[`ANG_EV_PAGE] |=> ist[`ANG_EV_PAGE]) // [R14]
    else $error("page event not recorded");

  // Main scenarios worth seeing at least once
  c_page: cover property (PAGE_RX ##1 rd_exp);
  c_link_down: cover property (CE && LINK_DOWN);
  c_restart: cover property (wr_ctrl && WDATA[9] ##1 AN_RESTART);
  c_irq: cover property (!IRQ ##1 IRQ);
  c_swrst: cover property (sw_rst);

endmodule

`default_nettype wire

// file: test/ang_link_partner.sv
// Link partner model: sends base pages and holds its ability levels
`timescale 1ns/10ps
`default_nettype none
module ang_link_partner
  import ang_pkg::*;
(
  input wire logic clk,
  input wire logic send,
  input wire ang_page_t word,
  input wire logic [2:0] abil,
  output logic page_rx,
  output ang_page_t page_word,
  output logic [2:0] flags
);
  // Word is inverted each cycle outside the pulse, so a stale page matches again every second cycle
  always_ff @(posedge clk) begin
    page_rx <= send;
    page_word <= send ? word : ~page_word;
    flags <= abil;
  end
endmodule
`default_nettype wire

// file: test/ang_regs_bench.sv
// Self-checking bench for the negotiation register bank
`timescale 1ns/10ps
`default_nettype none
`include "ang_params.svh"
module ang_regs_bench;
  import ang_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic ce = 1'h1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic send = 1'h0;
  logic an_complete = 1'h0;
  logic link_down = 1'h0;
  logic [2:0] abil = 3'h0;
  ang_page_t word = 16'h0000;
  logic [15:0] rdata;
  logic page_rx;
  ang_page_t page_word;
  logic [2:0] flags;
  logic an_restart;
  ang_adv_t adv_word;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  logic [15:0] v, adv, applied;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ang_regs ang_regs_i (.CLK(clk), .RESET(reset), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PAGE_RX(page_rx), .PAGE_WORD(page_word),
    .PD_FAULT(flags[0]), .PARTNER_NP_ABLE(flags[1]), .PARTNER_AN_ABLE(flags[2]),
    .AN_COMPLETE(an_complete), .LINK_DOWN(link_down), .AN_RESTART(an_restart),
    .ADV_WORD(adv_word), .IRQ(irq));
  ang_link_partner ang_link_partner_i (.clk(clk), .send(send), .word(word), .abil(abil),
    .page_rx(page_rx), .page_word(page_word), .flags(flags));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes; each task lets an edge pass so strobes never double up
  task wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  task rchk(input logic [4:0] a, input logic [15:0] exp);
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // Advertisement as it reads back: selector forced, other bits as written
  function automatic logic [15:0] adv_exp(input logic [15:0] d);
    return {d[15:5], `ANG_SEL_IEEE};
  endfunction

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end

  initial begin
    void'($urandom(32'hACE8E910));
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    applied = 16'h0C01;
    rchk(`ANG_OFS_ADV, 16'h0C01);
    chk(adv_word, 16'h0C01);
    rchk(`ANG_OFS_LPA, 16'h0000);
    rchk(`ANG_OFS_EXP, 16'h0004);
    // Every pause code, applied alternately by restart and by link loss
    for (int i = 0; i < 4; i++) begin
      adv = 16'($urandom);
      adv[15:14] = 2'h0;
      adv[11:10] = i[1:0];
      wr_reg(`ANG_OFS_ADV, adv);
      rchk(`ANG_OFS_ADV, adv_exp(adv));
      chk(adv_word, applied);
      applied = adv_exp(adv);
      if (i[0]) begin
        wr_reg(`ANG_OFS_CTRL, 16'h0200);
        #1 chk(16'(an_restart), 16'h0001);
        @(posedge clk);
        #1 chk(16'(an_restart), 16'h0000);
      end else begin
        @(posedge clk);
        link_down <= 1'h1;
        @(posedge clk);
        link_down <= 1'h0;
      end
      #1 chk(adv_word, applied);
    end
    rchk(`ANG_OFS_CTRL, 16'h0140);
    // Page arrives in the same cycle as the read that would clear its flag
    word <= 16'($urandom);
    @(posedge clk);
    send <= 1'h1;
    fork
      rd_reg(`ANG_OFS_EXP, v);
      begin
        @(posedge clk);
        send <= 1'h0;
      end
    join
    rchk(`ANG_OFS_EXP, 16'h0006);
    rchk(`ANG_OFS_EXP, 16'h0004);
    rchk(`ANG_OFS_LPA, word & 16'hEC1F);
    rchk(`ANG_OFS_IST, 16'h0001);
    chk(16'(irq), 16'h0000);
    wr_reg(`ANG_OFS_IMSK, 16'h0001);
    #1 chk(16'(irq), 16'h0001);
    wr_reg(`ANG_OFS_IST, 16'h0001);
    #1 chk(16'(irq), 16'h0000);
    // Live partner flags; expansion trusted only once completion reads one
    abil <= 3'h7;
    an_complete <= 1'h1;
    repeat (3) @(posedge clk);
    rchk(`ANG_OFS_STAT, 16'h0169);
    rchk(`ANG_OFS_EXP, 16'h001D);
    rchk(`ANG_OFS_IST, 16'h0006);
    wr_reg(`ANG_OFS_IMSK, 16'h0006);
    #1 chk(16'(irq), 16'h0001);
    wr_reg(5'h1F, 16'hFFFF);
    rchk(5'h1F, 16'h0000);
    // Soft reset keeps fault and pause, clears partner state
    abil <= 3'h0;
    an_complete <= 1'h0;
    wr_reg(`ANG_OFS_CTRL, 16'h8000);
    repeat (3) @(posedge clk);
    rchk(`ANG_OFS_ADV, (applied & 16'h3C00) | 16'h0001);
    rchk(`ANG_OFS_LPA, 16'h0000);
    rchk(`ANG_OFS_EXP, 16'h0004);
    rchk(`ANG_OFS_STAT, 16'h0149);
    // Writes with the clock enable low are ignored
    ce <= 1'h0;
    wr_reg(`ANG_OFS_ADV, 16'h0000);
    ce <= 1'h1;
    rchk(`ANG_OFS_ADV, (applied & 16'h3C00) | 16'h0001);
    // Hard reset in mid-run clears the fault flag
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rchk(`ANG_OFS_ADV, 16'h0C01);
    chk(adv_word, 16'h0C01);
    finish_test;
  end
endmodule
`default_nettype wire
